//--- scc_pkg.sv
// constants, field layouts and carrier types of the channel clock/status block
package scc_pkg;

   // register indices on the write side
   localparam logic [3:0] W_CMD_IDX      = 4'h0;
   localparam logic [3:0] W_IRQ_STAT_IDX = 4'h6;
   localparam logic [3:0] W_IRQ_MASK_IDX = 4'h7;
   localparam logic [3:0] W_LINE_IDX     = 4'hA;
   localparam logic [3:0] W_CLK_IDX      = 4'hB;
   localparam logic [3:0] W_MISC_IDX     = 4'hE;
   localparam logic [3:0] W_EXT_EN_IDX   = 4'hF;

   // register indices on the read side
   localparam logic [3:0] R_STATUS_IDX   = 4'h0;
   localparam logic [3:0] R_SPECIAL_IDX  = 4'h1;
   localparam logic [3:0] R_PENDING_IDX  = 4'h3;
   localparam logic [3:0] R_IRQ_STAT_IDX = 4'h6;
   localparam logic [3:0] R_IRQ_MASK_IDX = 4'h7;
   localparam logic [3:0] R_LOOP_IDX     = 4'hA;
   localparam logic [3:0] R_READBACK_IDX = 4'hF;

   // command register bits
   localparam int CMD_RST_EXT_BIT = 0;
   localparam int CMD_RST_TX_BIT  = 1;

   // clock source code that selects the baud generator
   localparam logic [1:0] CLK_SRC_BRG = 2'h2;

   // clock command codes
   localparam logic [2:0] CC_NULL       = 3'h0;
   localparam logic [2:0] CC_SEARCH     = 3'h1;
   localparam logic [2:0] CC_RST_MISS   = 3'h2;
   localparam logic [2:0] CC_DPLL_OFF   = 3'h3;
   localparam logic [2:0] CC_SRC_BRG    = 3'h4;
   localparam logic [2:0] CC_SRC_PIN    = 3'h5;
   localparam logic [2:0] CC_MODE_FM    = 3'h6;
   localparam logic [2:0] CC_MODE_NRZI  = 3'h7;

   // ext/status enable layout: writable bits, rest forced to zero
   localparam logic [7:0] EXT_EN_WMASK  = 8'hFA;
   localparam logic [7:0] READBACK_MASK = 8'hF0;

   // interrupt status bit positions
   localparam int IRQ_EXT_BIT  = 0;
   localparam int IRQ_RX_BIT   = 1;
   localparam int IRQ_TX_BIT   = 2;
   localparam int IRQ_MISS_BIT = 3;
   localparam int IRQ_W        = 4;

   // reset values
   localparam logic [7:0] LINE_RST   = 8'h00;
   localparam logic [7:0] CLK_RST    = 8'h50;
   localparam logic [7:0] MISC_RST   = 8'h00;
   localparam logic [7:0] EXT_EN_RST = 8'h00;

   typedef enum logic [1:0] {
      ENC_NRZ  = 2'h0,
      ENC_NRZI = 2'h1,
      ENC_FM1  = 2'h2,
      ENC_FM0  = 2'h3
   } scc_enc_type;

   typedef enum logic [1:0] {
      DPLL_OFF,
      DPLL_FM,
      DPLL_NRZI
   } scc_dpll_type;

   typedef struct packed {
      logic        crc_preset;
      scc_enc_type encoding;
      logic        active_on_poll;
      logic        mark_on_idle;
      logic        abort_on_idle;
      logic        loop_mode;
      logic        sync_six_bit;
   } scc_line_type;

   typedef struct packed {
      logic       xtal;
      logic [1:0] rx_src;
      logic [1:0] tx_src;
      logic       clk_out_en;
      logic [1:0] unused;
   } scc_clk_type;

   typedef struct packed {
      logic [2:0] cmd;
      logic       local_loop;
      logic       auto_echo;
      logic       dtr_request;
      logic       brg_source;
      logic       brg_enable;
   } scc_misc_type;

endpackage

//--- scc_sync.sv
// two-flop synchroniser for pin inputs
module scc_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             sys_clk,
   input  wire logic             resetn,
   // async in, synced out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

//--- scc_chan.sv
// one serial channel: line/clock config, clock commands, status and pending
// Summary of operation
// - the encoding field of the line control register selects NRZ, NRZI, FM1 or FM0 by 00..11.
// - line control bits 4..0 hold active-on-poll, mark idle, abort idle, loop and six-bit sync.
// - receive clock source 10 in bits 6:5 selects the baud generator; other codes are reserved.
// - transmit clock source 10 in bits 4:3 selects the baud generator; other codes are reserved.
// - clock command 000 is null, 001 starts search, 010 resets missing clock, 011 stops the loop.
// - clock command 100 picks the baud generator as loop source, 101 picks the external pin.
// - clock command 110 sets FM recovery, 111 sets NRZI recovery.
// - ext/status enables sit in bits 7,6,5,4,3,1 and bits 2 and 0 are written as zero.
// - the status register shows break, underrun, CTS, sync, DCD, tx empty, zero count, rx avail.
// - pending flags read zero on channel B and on channel A show 00 then A and B rx, tx, ext.
// - the readback register returns the break, underrun, CTS and sync enables in bits 7..4.
//
// Added by the designer: the address map and strobed register access.
module scc_chan #(
   parameter bit IS_CHAN_A = 1'b1
) (
   // clock and reset
   input  wire logic                   sys_clk,
   input  wire logic                   resetn,
   // register port
   input  wire logic [3:0]             reg_addr,
   input  wire logic [7:0]             reg_wdata,
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   output logic      [7:0]             reg_rdata,
   // modem pins
   input  wire logic                   cts_pin,
   input  wire logic                   dcd_pin,
   input  wire logic                   sync_pin,
   // datapath status
   input  wire logic                   break_abort,
   input  wire logic                   tx_underrun,
   input  wire logic                   tx_buf_empty,
   input  wire logic                   zero_count,
   input  wire logic                   rx_char_avail,
   input  wire logic [7:0]             special_rx,
   input  wire logic                   one_clk_missing,
   input  wire logic                   two_clk_missing,
   input  wire logic                   loop_sending,
   input  wire logic                   on_loop,
   // pending flags of the other channel: rx, tx, ext
   input  wire logic [2:0]             peer_pending,
   // configuration out
   output scc_pkg::scc_line_type       line_ctrl,
   output scc_pkg::scc_clk_type        clk_ctrl,
   output scc_pkg::scc_misc_type       misc_ctrl,
   output logic      [7:0]             ext_enable,
   output logic                        rx_clk_brg,
   output logic                        tx_clk_brg,
   // loop control out
   output scc_pkg::scc_dpll_type       dpll_mode,
   output logic                        dpll_src_pin,
   output logic                        dpll_search,
   output logic                        miss_clk_reset,
   // own pending flags: rx, tx, ext
   output logic      [2:0]             own_pending,
   // interrupt
   output logic                        irq
);

   if (IS_CHAN_A !== 1'b0 && IS_CHAN_A !== 1'b1) begin : g_bad_chan
      $error("IS_CHAN_A must be 0 or 1");
   end

   localparam int IRQ_W_L = scc_pkg::IRQ_W;

   logic [2:0]             pins_s;
   logic                   cts_s;
   logic                   dcd_s;
   logic                   sync_s;
   logic [7:0]             status_vec;
   logic [5:0]             ext_vec;
   logic [5:0]             ext_prev_q;
   logic [5:0]             ext_en6;
   logic                   ext_change;
   logic                   ext_pend_q;
   logic                   tx_pend_q;
   logic                   tx_empty_q;
   logic                   rx_avail_q;
   logic                   miss_q;
   logic [IRQ_W_L-1:0]     irq_stat_q;
   logic [IRQ_W_L-1:0]     irq_mask_q;
   logic [IRQ_W_L-1:0]     irq_set;
   logic [7:0]             pend_vec;
   logic [7:0]             rd_d;
   logic                   wr_cmd;
   logic                   wr_misc;

   scc_sync #(
      .WIDTH(3)
   ) u_pin_sync (
      .sys_clk  (sys_clk),
      .resetn   (resetn),
      .async_in ({cts_pin, dcd_pin, sync_pin}),
      .sync_out (pins_s)
   );

   assign cts_s  = pins_s[2];
   assign dcd_s  = pins_s[1];
   assign sync_s = pins_s[0];

   assign wr_cmd  = reg_wr && (reg_addr == scc_pkg::W_CMD_IDX);
   assign wr_misc = reg_wr && (reg_addr == scc_pkg::W_MISC_IDX);

   // line control register
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         line_ctrl <= scc_pkg::LINE_RST;
      end else if (reg_wr && reg_addr == scc_pkg::W_LINE_IDX) begin
         line_ctrl <= reg_wdata;
      end
   end

   // clock source control; reserved codes are kept but do not select the generator
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         clk_ctrl   <= scc_pkg::CLK_RST;
         rx_clk_brg <= 1'b1;
         tx_clk_brg <= 1'b1;
      end else if (reg_wr && reg_addr == scc_pkg::W_CLK_IDX) begin
         clk_ctrl   <= reg_wdata;
         rx_clk_brg <= (reg_wdata[6:5] == scc_pkg::CLK_SRC_BRG);
         tx_clk_brg <= (reg_wdata[4:3] == scc_pkg::CLK_SRC_BRG);
      end
   end

   // misc control: all bits stored, command field included and acted on once
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         misc_ctrl <= scc_pkg::MISC_RST;
      end else if (wr_misc) begin
         misc_ctrl <= reg_wdata;
      end
   end

   // clock command decode; pulses last one cycle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         dpll_mode      <= scc_pkg::DPLL_OFF;
         dpll_src_pin   <= 1'b0;
         dpll_search    <= 1'b0;
         miss_clk_reset <= 1'b0;
      end else begin
         dpll_search    <= 1'b0;
         miss_clk_reset <= 1'b0;
         if (wr_misc) begin
            case (reg_wdata[7:5])
               scc_pkg::CC_NULL: begin
               end
               scc_pkg::CC_SEARCH: begin
                  dpll_search <= 1'b1;
               end
               scc_pkg::CC_RST_MISS: begin
                  miss_clk_reset <= 1'b1;
               end
               scc_pkg::CC_DPLL_OFF: begin
                  dpll_mode <= scc_pkg::DPLL_OFF;
               end
               scc_pkg::CC_SRC_BRG: begin
                  dpll_src_pin <= 1'b0;
               end
               scc_pkg::CC_SRC_PIN: begin
                  dpll_src_pin <= 1'b1;
               end
               scc_pkg::CC_MODE_FM: begin
                  dpll_mode <= scc_pkg::DPLL_FM;
               end
               scc_pkg::CC_MODE_NRZI: begin
                  dpll_mode <= scc_pkg::DPLL_NRZI;
               end
               default: begin
               end
            endcase
         end
      end
   end

   // ext/status enables; reserved bits never stored
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ext_enable <= scc_pkg::EXT_EN_RST;
      end else if (reg_wr && reg_addr == scc_pkg::W_EXT_EN_IDX) begin
         ext_enable <= reg_wdata & scc_pkg::EXT_EN_WMASK;
      end
   end

   assign status_vec = {break_abort, tx_underrun, cts_s, sync_s,
                        dcd_s, tx_buf_empty, zero_count, rx_char_avail};

   // change detection covers only conditions that have an enable
   assign ext_vec    = {status_vec[7:3], zero_count};
   assign ext_en6    = {ext_enable[7:3], ext_enable[1]};
   assign ext_change = |((ext_vec ^ ext_prev_q) & ext_en6);

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ext_prev_q <= '0;
         tx_empty_q <= 1'b0;
         rx_avail_q <= 1'b0;
         miss_q     <= 1'b0;
      end else begin
         ext_prev_q <= ext_vec;
         tx_empty_q <= tx_buf_empty;
         rx_avail_q <= rx_char_avail;
         miss_q     <= one_clk_missing;
      end
   end

   // set wins over a reset command in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ext_pend_q <= 1'b0;
      end else if (ext_change) begin
         ext_pend_q <= 1'b1;
      end else if (wr_cmd && reg_wdata[scc_pkg::CMD_RST_EXT_BIT]) begin
         ext_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         tx_pend_q <= 1'b0;
      end else if (tx_buf_empty && !tx_empty_q) begin
         tx_pend_q <= 1'b1;
      end else if (wr_cmd && reg_wdata[scc_pkg::CMD_RST_TX_BIT]) begin
         tx_pend_q <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         own_pending <= '0;
      end else begin
         own_pending <= {rx_char_avail, tx_pend_q, ext_pend_q};
      end
   end

   // sticky interrupt status, write one to clear
   assign irq_set[scc_pkg::IRQ_EXT_BIT]  = ext_change;
   assign irq_set[scc_pkg::IRQ_RX_BIT]   = rx_char_avail && !rx_avail_q;
   assign irq_set[scc_pkg::IRQ_TX_BIT]   = tx_buf_empty && !tx_empty_q;
   assign irq_set[scc_pkg::IRQ_MISS_BIT] = one_clk_missing && !miss_q;

   generate
      for (genvar i = 0; i < IRQ_W_L; i++) begin : g_irq
         always_ff @(posedge sys_clk) begin
            if (!resetn) begin
               irq_stat_q[i] <= 1'b0;
            end else if (irq_set[i]) begin
               irq_stat_q[i] <= 1'b1;
            end else if (reg_wr && reg_addr == scc_pkg::W_IRQ_STAT_IDX && reg_wdata[i]) begin
               irq_stat_q[i] <= 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         irq_mask_q <= '0;
      end else if (reg_wr && reg_addr == scc_pkg::W_IRQ_MASK_IDX) begin
         irq_mask_q <= reg_wdata[IRQ_W_L-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irq_stat_q & irq_mask_q);
      end
   end

   // pending flags only meaningful through channel A
   assign pend_vec = IS_CHAN_A ? {2'h0, own_pending, peer_pending} : 8'h00;

   always_comb begin
      rd_d = 8'h00;
      case (reg_addr)
         scc_pkg::R_STATUS_IDX:   rd_d = status_vec;
         scc_pkg::R_SPECIAL_IDX:  rd_d = special_rx;
         scc_pkg::R_PENDING_IDX:  rd_d = pend_vec;
         scc_pkg::R_IRQ_STAT_IDX: rd_d = {{(8-IRQ_W_L){1'b0}}, irq_stat_q};
         scc_pkg::R_IRQ_MASK_IDX: rd_d = {{(8-IRQ_W_L){1'b0}}, irq_mask_q};
         scc_pkg::R_LOOP_IDX:     rd_d = {one_clk_missing, two_clk_missing, 1'b0,
                                          loop_sending, 2'h0, on_loop, 1'b0};
         scc_pkg::R_READBACK_IDX: rd_d = ext_enable & scc_pkg::READBACK_MASK;
         default:                 rd_d = 8'h00;
      endcase
   end

   // data valid only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rd_d;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   sequence s_wr(logic [3:0] idx);
      reg_wr && reg_addr == idx;
   endsequence

   sequence s_rd(logic [3:0] idx);
      reg_rd && reg_addr == idx;
   endsequence

   sequence s_cmd(logic [2:0] code);
      s_wr(scc_pkg::W_MISC_IDX) ##0 reg_wdata[7:5] == code;
   endsequence

   chk_line_encoding: assert property (
      s_wr(scc_pkg::W_LINE_IDX) |=> line_ctrl.encoding == $past(reg_wdata[6:5])
   ) else $error("encoding field not taken");

   chk_line_low_bits: assert property (
      s_wr(scc_pkg::W_LINE_IDX) ##1 !(reg_wr && reg_addr == scc_pkg::W_LINE_IDX)
      |=> line_ctrl[4:0] == $past(reg_wdata[4:0], 2)
   ) else $error("line control low bits wrong");

   chk_rx_clock_src: assert property (
      s_wr(scc_pkg::W_CLK_IDX) |=> rx_clk_brg == ($past(reg_wdata[6:5]) == 2'h2)
   ) else $error("receive clock source decode wrong");

   chk_tx_clock_src: assert property (
      s_wr(scc_pkg::W_CLK_IDX) |=> tx_clk_brg == ($past(reg_wdata[4:3]) == 2'h2)
   ) else $error("transmit clock source decode wrong");

   chk_search_pulse: assert property (
      s_cmd(scc_pkg::CC_SEARCH) ##1
      !(reg_wr && reg_addr == scc_pkg::W_MISC_IDX && reg_wdata[7:5] == scc_pkg::CC_SEARCH)
      |-> dpll_search ##1 !dpll_search
   ) else $error("search pulse not one cycle");

   chk_dpll_off: assert property (
      s_cmd(scc_pkg::CC_DPLL_OFF) |=> dpll_mode == scc_pkg::DPLL_OFF && !dpll_search
   ) else $error("loop not disabled");

   chk_dpll_source: assert property (
      (s_cmd(scc_pkg::CC_SRC_PIN) |=> dpll_src_pin) and
      (s_cmd(scc_pkg::CC_SRC_BRG) |=> !dpll_src_pin)
   ) else $error("loop source select wrong");

   chk_dpll_recovery: assert property (
      (s_cmd(scc_pkg::CC_MODE_FM) |=> dpll_mode == scc_pkg::DPLL_FM) and
      (s_cmd(scc_pkg::CC_MODE_NRZI) |=> dpll_mode == scc_pkg::DPLL_NRZI)
   ) else $error("recovery mode wrong");

   chk_ext_reserved: assert property (
      s_wr(scc_pkg::W_EXT_EN_IDX) |=> ext_enable[2] == 1'b0 && ext_enable[0] == 1'b0
      && ext_enable[7] == $past(reg_wdata[7]) && ext_enable[1] == $past(reg_wdata[1])
   ) else $error("ext enable layout wrong");

   chk_status_read: assert property (
      s_rd(scc_pkg::R_STATUS_IDX) |=> reg_rdata[7] == $past(break_abort)
      && reg_rdata[0] == $past(rx_char_avail) && reg_rdata[5] == $past(cts_s)
   ) else $error("status read wrong");

   chk_pending_read: assert property (
      s_rd(scc_pkg::R_PENDING_IDX) |=> reg_rdata[7:6] == 2'h0
      && (IS_CHAN_A || reg_rdata == 8'h00)
      && (!IS_CHAN_A || reg_rdata[2:0] == $past(peer_pending))
   ) else $error("pending read wrong");

   chk_enable_readback: assert property (
      s_rd(scc_pkg::R_READBACK_IDX) |=> reg_rdata[7:4] == $past(ext_enable[7:4])
   ) else $error("enable readback wrong");

   chk_ext_pend_cause: assert property (
      $rose(ext_pend_q) |-> $past(ext_change)
   ) else $error("ext pending set without enabled change");

   chk_ext_pend_clear: assert property (
      ext_pend_q && !ext_change && wr_cmd && reg_wdata[0] |=> !ext_pend_q
   ) else $error("ext pending not cleared");

   chk_irq_level: assert property (
      ##1 irq == $past(|(irq_stat_q & irq_mask_q))
   ) else $error("irq level wrong");

   chk_read_one_cycle: assert property (
      !reg_rd |=> reg_rdata == 8'h00
   ) else $error("read data held too long");

endmodule

//--- scc_peer.sv
// serial line peer: modem lines that follow the bench's wishes after a lag
module scc_peer #(
   parameter int LAG_NS = 7
) (
   // wishes from the bench
   input  wire logic want_cts,
   input  wire logic want_dcd,
   input  wire logic want_sync,
   // modem lines toward the channel
   output logic      cts_pin,
   output logic      dcd_pin,
   output logic      sync_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // lines move off the clock grid, as a real modem's would
   initial begin
      cts_pin = 1'b0;
      dcd_pin = 1'b0;
      sync_pin = 1'b0;
   end
   always @(want_cts) cts_pin <= #LAG_NS want_cts;
   always @(want_dcd) dcd_pin <= #LAG_NS want_dcd;
   always @(want_sync) sync_pin <= #LAG_NS want_sync;
endmodule

//--- scc_chan_test.sv
// self-checking bench of one channel's clock, status and pending registers
module scc_chan_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk, resetn, reg_wr, reg_rd, w_cts, w_dcd, w_sync, cts_pin, dcd_pin, sync_pin;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, special_rx, rd_v;
   logic break_abort, tx_underrun, tx_buf_empty, zero_count, rx_char_avail;
   logic one_clk_missing, two_clk_missing, loop_sending, on_loop, irq;
   logic [2:0] peer_pending, own_pending;
   logic [7:0] ext_enable;
   logic rx_clk_brg, tx_clk_brg, dpll_src_pin, dpll_search, miss_clk_reset;
   scc_pkg::scc_line_type line_ctrl;
   scc_pkg::scc_clk_type clk_ctrl;
   scc_pkg::scc_misc_type misc_ctrl;
   scc_pkg::scc_dpll_type dpll_mode, exp_mode;
   logic exp_src;
   logic [2:0] c;
   logic [2:0] c_seq [8] = '{3'h6, 3'h3, 3'h7, 3'h4, 3'h5, 3'h2, 3'h0, 3'h1};
   logic [7:0] rdata_b;
   int err_total, checks;

   scc_peer peer_u (.want_cts(w_cts), .want_dcd(w_dcd), .want_sync(w_sync),
      .cts_pin(cts_pin), .dcd_pin(dcd_pin), .sync_pin(sync_pin));

   scc_chan dut_u (.sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cts_pin(cts_pin), .dcd_pin(dcd_pin), .sync_pin(sync_pin),
      .break_abort(break_abort), .tx_underrun(tx_underrun), .tx_buf_empty(tx_buf_empty),
      .zero_count(zero_count), .rx_char_avail(rx_char_avail), .special_rx(special_rx),
      .one_clk_missing(one_clk_missing), .two_clk_missing(two_clk_missing),
      .loop_sending(loop_sending), .on_loop(on_loop), .peer_pending(peer_pending),
      .line_ctrl(line_ctrl), .clk_ctrl(clk_ctrl), .misc_ctrl(misc_ctrl),
      .ext_enable(ext_enable), .rx_clk_brg(rx_clk_brg), .tx_clk_brg(tx_clk_brg),
      .dpll_mode(dpll_mode), .dpll_src_pin(dpll_src_pin), .dpll_search(dpll_search),
      .miss_clk_reset(miss_clk_reset), .own_pending(own_pending), .irq(irq));

   // second channel only to see the pending register read through channel B
   scc_chan #(.IS_CHAN_A(1'b0)) chan_b_u (.sys_clk(sys_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(rdata_b), .cts_pin(cts_pin), .dcd_pin(dcd_pin), .sync_pin(sync_pin),
      .break_abort(break_abort), .tx_underrun(tx_underrun), .tx_buf_empty(tx_buf_empty),
      .zero_count(zero_count), .rx_char_avail(rx_char_avail), .special_rx(special_rx),
      .one_clk_missing(one_clk_missing), .two_clk_missing(two_clk_missing),
      .loop_sending(loop_sending), .on_loop(on_loop), .peer_pending(peer_pending),
      .line_ctrl(), .clk_ctrl(), .misc_ctrl(), .ext_enable(), .rx_clk_brg(),
      .tx_clk_brg(), .dpll_mode(), .dpll_src_pin(), .dpll_search(), .miss_clk_reset(),
      .own_pending(), .irq());

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      #1;
   endtask

   // read data stand only in the cycle after the strobe, so sample there
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp, input string what);
      rd(a, rd_v);
      chk(rd_v, exp, what);
   endtask

   // drive the status sources in the order of the status register
   task automatic stat(input logic [7:0] v);
      @(posedge sys_clk);
      {break_abort, tx_underrun} <= v[7:6];
      {w_cts, w_sync, w_dcd} <= v[5:3];
      {tx_buf_empty, zero_count, rx_char_avail} <= v[2:0];
      tick(4);
   endtask

   task automatic results;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      results;
   end

   initial begin
      {resetn, reg_wr, reg_rd, reg_addr, reg_wdata, special_rx} = '0;
      {w_cts, w_dcd, w_sync, break_abort, tx_underrun, tx_buf_empty} = '0;
      {zero_count, rx_char_avail, one_clk_missing, two_clk_missing} = '0;
      {loop_sending, on_loop} = '0;
      peer_pending = 3'h5;
      err_total = 0;
      checks = 0;
      repeat (10) @(posedge sys_clk);
      resetn <= 1'b1;
      #1;
      chk(clk_ctrl, 8'h50, "clock reset");
      chk(8'(rx_clk_brg & tx_clk_brg), 8'h01, "brg reset");
      chk(8'(dpll_mode), 8'(scc_pkg::DPLL_OFF), "loop reset");
      chk(ext_enable, 8'h00, "enable reset");
      rd_chk(scc_pkg::R_IRQ_MASK_IDX, 8'h00, "mask reset");
      for (int i = 0; i < 4; i++) begin
         wr(scc_pkg::W_LINE_IDX, 8'(i << 5));
         chk(8'(line_ctrl.encoding), 8'(i), "encoding");
         wr(scc_pkg::W_CLK_IDX, 8'((i << 5) | ((3 - i) << 3)));
         chk(8'(rx_clk_brg), 8'(i == 2), "rx source");
         chk(8'(tx_clk_brg), 8'(i == 1), "tx source");
      end
      chk(clk_ctrl, 8'h60, "clock stored");
      wr(scc_pkg::W_LINE_IDX, 8'h15);
      chk(8'({line_ctrl.active_on_poll, line_ctrl.mark_on_idle, line_ctrl.abort_on_idle,
              line_ctrl.loop_mode, line_ctrl.sync_six_bit}), 8'h15, "line low bits");
      // commands are pulses or mode changes; search goes last so mode is unambiguous
      exp_mode = scc_pkg::DPLL_OFF;
      exp_src = 1'b0;
      foreach (c_seq[k]) begin
         c = c_seq[k];
         wr(scc_pkg::W_MISC_IDX, {c, 5'h00});
         case (c)
            3'h3: exp_mode = scc_pkg::DPLL_OFF;
            3'h4: exp_src = 1'b0;
            3'h5: exp_src = 1'b1;
            3'h6: exp_mode = scc_pkg::DPLL_FM;
            3'h7: exp_mode = scc_pkg::DPLL_NRZI;
            default: ;
         endcase
         chk(8'(dpll_search), 8'(c == 3'h1), "search pulse");
         chk(8'(miss_clk_reset), 8'(c == 3'h2), "miss reset pulse");
         chk(8'(dpll_mode), 8'(exp_mode), "loop mode");
         chk(8'(dpll_src_pin), 8'(exp_src), "loop source");
         tick(1);
         chk(8'(dpll_search | miss_clk_reset), 8'h00, "pulse end");
      end
      chk(misc_ctrl, 8'h20, "misc stored");
      wr(scc_pkg::W_EXT_EN_IDX, 8'hFF);
      chk(ext_enable, 8'hFA, "enable bits");
      rd_chk(scc_pkg::R_READBACK_IDX, 8'hF0, "readback");
      wr(scc_pkg::W_EXT_EN_IDX, 8'h00);
      rd_chk(scc_pkg::R_READBACK_IDX, 8'h00, "readback low");
      stat(8'hAA);
      rd_chk(scc_pkg::R_STATUS_IDX, 8'hAA, "status A");
      stat(8'h55);
      rd_chk(scc_pkg::R_STATUS_IDX, 8'h55, "status 5");
      stat(8'h00);
      @(posedge sys_clk);
      special_rx <= 8'h5A;
      {one_clk_missing, two_clk_missing, loop_sending, on_loop} <= 4'hF;
      rd_chk(scc_pkg::R_SPECIAL_IDX, 8'h5A, "special");
      rd_chk(scc_pkg::R_LOOP_IDX, 8'hD2, "loop status");
      rd_chk(4'h2, 8'h00, "unmapped");
      // pending: a change of a disabled condition must not flag
      wr(scc_pkg::W_CMD_IDX, 8'h03);
      stat(8'h08);
      chk(8'(own_pending), 8'h00, "ext disabled");
      wr(scc_pkg::W_EXT_EN_IDX, 8'h08);
      stat(8'h00);
      chk(8'(own_pending), 8'h01, "ext enabled");
      rd_chk(scc_pkg::R_PENDING_IDX, 8'h0D, "pending");
      chk(rdata_b, 8'h00, "pending via B");
      wr(scc_pkg::W_CMD_IDX, 8'h01);
      tick(1);
      chk(8'(own_pending), 8'h00, "ext cleared");
      // interrupt: sticky status, mask, level output
      rd_chk(scc_pkg::R_IRQ_STAT_IDX, 8'h0F, "irq status all");
      wr(scc_pkg::W_IRQ_STAT_IDX, 8'h0F);
      rd_chk(scc_pkg::R_IRQ_STAT_IDX, 8'h00, "irq status clear");
      wr(scc_pkg::W_IRQ_MASK_IDX, 8'h02);
      stat(8'h01);
      chk(8'(irq), 8'h01, "irq raised");
      rd_chk(scc_pkg::R_IRQ_STAT_IDX, 8'h02, "irq status rx");
      wr(scc_pkg::W_IRQ_MASK_IDX, 8'h00);
      tick(1);
      chk(8'(irq), 8'h00, "irq masked");
      wr(scc_pkg::W_IRQ_MASK_IDX, 8'h02);
      tick(1);
      chk(8'(irq), 8'h01, "irq unmasked");
      wr(scc_pkg::W_IRQ_STAT_IDX, 8'h02);
      tick(1);
      chk(8'(irq), 8'h00, "irq cleared");
      results;
   end

endmodule
